// ==== hw/swire_device.sv ====
// Device end: reset/presence, write and read slots, CRC-16 framing.
// Assumes the interface resolves the wire; bytes to send come in via a
// FIFO of its own, received bytes go out as a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none
module swire_device (
  input wire logic sys_clk,
  input wire logic rst_b,
  swire_if.device bus,
  input wire logic txValid, // Byte to send on read slots
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic crcClear, // Start a new CRC frame
  input wire logic crcSend, // Next tx bytes are inverted CRC
  output logic rxValid,
  output logic [7:0] rxData,
  output logic fastMode,
  output logic presenceDone,
  output logic [15:0] crcValue
);
  // ---------------------------------------------------------------
  // Transmit FIFO
  // ---------------------------------------------------------------
  logic fifoValid, fifoReady;
  logic [7:0] fifoData;
  sync_fifo #(.WIDTH(8), .DEPTH(16)) txFifo (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .inValid(txValid), .inReady(txReady), .inData(txData),
    .outValid(fifoValid), .outReady(fifoReady), .outData(fifoData));

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, // Line high, waiting for a fall
    S_LOW = 2'h1, // Master holding low, timing it
    S_PWAIT = 2'h2, // Presence wait after reset
    S_PLOW = 2'h3 // Presence pulse driven
  } dstate_t;
  typedef struct packed {
    logic sync1, sync2, lineD; // Synchroniser and last level
    dstate_t st;
    logic [swire_pkg::CNT_W-1:0] cnt; // Restarted on a fall seen in S_IDLE and on entering S_PWAIT or S_PLOW
    logic fast;
    logic drive; // Pull the line low
    logic [7:0] txSh, rxSh;
    logic [2:0] txBit, rxBit;
    logic txHave, crcMode;
    logic [1:0] crcByte; // Which CRC byte is being sent
    logic [15:0] crc;
    logic sampled; // Write bit taken this slot
    logic rxV, pres;
    logic [7:0] rxD;
  } dev_t;
  dev_t s_r, s_nxt;
  logic pop;

  // Next-state logic
  always_comb begin
    logic fell, line, bitIn;
    logic [swire_pkg::CNT_W-1:0] sampAt, validAt, rdet;
    s_nxt = s_r;
    pop = 1'b0;
    s_nxt.sync1 = bus.lineIn;
    s_nxt.sync2 = s_r.sync1;
    line = s_r.sync2;
    s_nxt.lineD = line;
    fell = s_r.lineD && !line;
    bitIn = 1'b0;
    s_nxt.rxV = 1'b0;
    s_nxt.pres = 1'b0;
    sampAt = s_r.fast ? swire_pkg::CNT_W'(swire_pkg::FAST_SAMPLE_CYC)
                      : swire_pkg::CNT_W'(swire_pkg::REG_SAMPLE_CYC);
    validAt = s_r.fast ? swire_pkg::CNT_W'(swire_pkg::FAST_VALID_CYC)
                       : swire_pkg::CNT_W'(swire_pkg::REG_VALID_CYC);
    rdet = s_r.fast ? swire_pkg::CNT_W'(swire_pkg::FAST_RDET_CYC)
                    : swire_pkg::CNT_W'(swire_pkg::REG_RDET_CYC);
    if (s_r.cnt != '1) s_nxt.cnt = s_r.cnt + 1'b1; // Saturate
    if (crcClear) s_nxt.crc = swire_pkg::CRC_INIT;
    if (crcSend) begin
      s_nxt.crcMode = 1'b1;
      s_nxt.crcByte = 2'h0;
    end
    // Load next byte to send
    if (!s_r.txHave) begin
      if (s_r.crcMode) begin
        s_nxt.txSh = s_r.crcByte[0] ? ~s_r.crc[15:8] : ~s_r.crc[7:0];
        s_nxt.txHave = 1'b1;
        s_nxt.txBit = 3'h0;
      end else if (fifoValid) begin
        pop = 1'b1;
        s_nxt.txSh = fifoData;
        s_nxt.txHave = 1'b1;
        s_nxt.txBit = 3'h0;
      end
    end
    unique case (s_r.st)
      S_IDLE: begin
        if (fell) begin
          s_nxt.st = S_LOW;
          s_nxt.cnt = '0;
          s_nxt.sampled = 1'b0;
          // Read slot: pull low at once for a zero bit
          s_nxt.drive = s_r.txHave && !s_r.txSh[0];
        end
      end
      S_LOW: begin
        // Release read data after the valid window
        if (s_r.cnt >= validAt) s_nxt.drive = 1'b0;
        // Sample write data mid-slot
        if (!s_r.sampled && s_r.cnt == sampAt) begin
          s_nxt.sampled = 1'b1;
          bitIn = !line ? 1'b0 : 1'b1;
          if (s_r.txHave) begin
            // Read slot: our own bit goes out, fold into CRC
            bitIn = s_r.txSh[0];
            s_nxt.txSh = {1'b0, s_r.txSh[7:1]};
            s_nxt.txBit = s_r.txBit + 1'b1;
            if (s_r.txBit == 3'h7) begin
              s_nxt.txHave = 1'b0;
              if (s_r.crcMode) begin
                s_nxt.crcByte = s_r.crcByte + 1'b1;
                if (s_r.crcByte[0]) s_nxt.crcMode = 1'b0;
              end
            end
          end else begin
            s_nxt.rxSh = {bitIn, s_r.rxSh[7:1]}; // LSB first
            s_nxt.rxBit = s_r.rxBit + 1'b1;
            if (s_r.rxBit == 3'h7) begin
              s_nxt.rxV = 1'b1;
              s_nxt.rxD = {bitIn, s_r.rxSh[7:1]};
            end
          end
          // CRC shift; sequence order comes from caller
          if (!s_r.crcMode) begin
            s_nxt.crc = {1'b0, s_r.crc[15:1]} ^
              ((s_r.crc[0] ^ bitIn) ? swire_pkg::CRC_POLY_REFL : 16'h0000);
          end
        end
        // Slot ends only after its mid-slot sample, so a short write-one
        // or read low still delivers its bit; long low is a reset
        if (line && s_r.sampled) begin
          if (s_r.cnt >= rdet) begin
            // a regular-length reset drops fast mode
            if (s_r.cnt >= swire_pkg::CNT_W'(swire_pkg::REG_RDET_CYC))
              s_nxt.fast = 1'b0;
            s_nxt.st = S_PWAIT;
            s_nxt.cnt = '0;
            s_nxt.txHave = 1'b0;
            s_nxt.crcMode = 1'b0;
            s_nxt.rxBit = 3'h0;
          end else begin
            s_nxt.st = S_IDLE;
          end
          s_nxt.drive = 1'b0;
        end
      end
      S_PWAIT: begin
        // Wait then pull presence
        if (s_r.cnt == (s_r.fast ?
            swire_pkg::CNT_W'(swire_pkg::FAST_PWAIT_CYC) :
            swire_pkg::CNT_W'(swire_pkg::REG_PWAIT_CYC))) begin
          s_nxt.st = S_PLOW;
          s_nxt.cnt = '0;
          s_nxt.drive = 1'b1;
        end
      end
      S_PLOW: begin
        if (s_r.cnt == (s_r.fast ?
            swire_pkg::CNT_W'(swire_pkg::FAST_PLOW_CYC) :
            swire_pkg::CNT_W'(swire_pkg::REG_PLOW_CYC))) begin
          s_nxt.st = S_IDLE;
          s_nxt.drive = 1'b0;
          s_nxt.pres = 1'b1;
          s_nxt.lineD = 1'b0; // Mask our own release as a fall
        end
      end
    endcase
  end
  assign fifoReady = pop;

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
      s_r.lineD <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign bus.devOe_b = !s_r.drive; // Low while pulling
  assign bus.devOut = 1'b0;
  assign rxValid = s_r.rxV;
  assign rxData = s_r.rxD;
  assign fastMode = s_r.fast;
  assign presenceDone = s_r.pres;
  assign crcValue = s_r.crc;
endmodule // swire_device
`default_nettype wire

// ==== shared/swire_pkg.sv ====
// Constants, types and timing figures shared by both ends of the link.
// Assumes a single 40 MHz system clock on each end.
// Behaviour
// - Auth page read CRC: cmd, addr, data, counters
// - Counters enter CRC least significant byte first
// - Hash compute CRC: cmd, addr low, high, control
// - Regular slots 60-120us, one 1-15us, zero 60-120us
// - Regular read bit valid until exactly 15us
// - Regular reset low and high at least 480us
// - Regular presence: wait 15-60us, low 60-240us
// - Fast slots 6-16us, one 1-2us, zero 6-16us
// - Fast read bit valid exactly 2us
// - Fast reset low 48-80us, high 48us
// - Fast presence: wait 2-6us, low 8-24us
// - Master reset low no longer than 960us
// - Read bit on line within 1us
// - Reset of 480us or more leaves fast mode
// - Read zero pulls low, one never pulls
// - CRC poly x16+x15+x2+1, sent inverted
package swire_pkg;
  // ---------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 40; // Cycles per microsecond

  // ---------------------------------------------------------------
  // Timing figures in microseconds
  // ---------------------------------------------------------------
  localparam int REG_SLOT_US = 70; // Master slot length, regular
  localparam int REG_ONE_LOW_US = 6;
  localparam int REG_ZERO_LOW_US = 65;
  localparam int REG_SAMPLE_US = 30; // Device samples write data
  localparam int REG_READ_VALID_US = 15;
  localparam int REG_MASTER_SAMPLE_US = 12;
  localparam int REG_RESET_LOW_US = 500;
  localparam int REG_RESET_HIGH_US = 500;
  localparam int REG_RESET_DETECT_US = 480;
  localparam int REG_PRES_WAIT_US = 30;
  localparam int REG_PRES_LOW_US = 120;
  localparam int FAST_SLOT_US = 10;
  localparam int FAST_ONE_LOW_US = 1;
  localparam int FAST_ZERO_LOW_US = 8;
  localparam int FAST_SAMPLE_US = 3;
  localparam int FAST_READ_VALID_US = 2;
  localparam int FAST_MASTER_SAMPLE_US = 1;
  localparam int FAST_RESET_LOW_US = 60;
  localparam int FAST_RESET_HIGH_US = 60;
  localparam int FAST_RESET_DETECT_US = 48;
  localparam int FAST_PRES_WAIT_US = 4;
  localparam int FAST_PRES_LOW_US = 16;
  localparam int RECOVERY_US = 2;

  // ---------------------------------------------------------------
  // Cycle counts derived from the figures
  // ---------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int REG_SLOT_CYC = REG_SLOT_US * CLK_MHZ;
  localparam int REG_ONE_CYC = REG_ONE_LOW_US * CLK_MHZ;
  localparam int REG_ZERO_CYC = REG_ZERO_LOW_US * CLK_MHZ;
  localparam int REG_SAMPLE_CYC = REG_SAMPLE_US * CLK_MHZ;
  localparam int REG_VALID_CYC = REG_READ_VALID_US * CLK_MHZ;
  localparam int REG_MSAMPLE_CYC = REG_MASTER_SAMPLE_US * CLK_MHZ;
  localparam int REG_RSTL_CYC = REG_RESET_LOW_US * CLK_MHZ;
  localparam int REG_RSTH_CYC = REG_RESET_HIGH_US * CLK_MHZ;
  localparam int REG_RDET_CYC = REG_RESET_DETECT_US * CLK_MHZ;
  localparam int REG_PWAIT_CYC = REG_PRES_WAIT_US * CLK_MHZ;
  localparam int REG_PLOW_CYC = REG_PRES_LOW_US * CLK_MHZ;
  localparam int FAST_SLOT_CYC = FAST_SLOT_US * CLK_MHZ;
  localparam int FAST_ONE_CYC = FAST_ONE_LOW_US * CLK_MHZ;
  localparam int FAST_ZERO_CYC = FAST_ZERO_LOW_US * CLK_MHZ;
  localparam int FAST_SAMPLE_CYC = FAST_SAMPLE_US * CLK_MHZ;
  localparam int FAST_VALID_CYC = FAST_READ_VALID_US * CLK_MHZ;
  localparam int FAST_MSAMPLE_CYC = FAST_MASTER_SAMPLE_US * CLK_MHZ;
  localparam int FAST_RSTL_CYC = FAST_RESET_LOW_US * CLK_MHZ;
  localparam int FAST_RSTH_CYC = FAST_RESET_HIGH_US * CLK_MHZ;
  localparam int FAST_RDET_CYC = FAST_RESET_DETECT_US * CLK_MHZ;
  localparam int FAST_PWAIT_CYC = FAST_PRES_WAIT_US * CLK_MHZ;
  localparam int FAST_PLOW_CYC = FAST_PRES_LOW_US * CLK_MHZ;
  localparam int REC_CYC = RECOVERY_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // CRC
  // ---------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001; // x16+x15+x2+1
  localparam logic [7:0] CMD_AUTH_READ = 8'ha5; // Auth page read
  localparam logic [7:0] CMD_HASH = 8'h33; // Hash compute

  // Master operations
  typedef enum logic [1:0] {
    OP_RESET = 2'h0,
    OP_WRITE = 2'h1,
    OP_READ = 2'h2
  } op_t;
endpackage

// ==== shared/swire_if.sv ====
// Single wire open-drain link joining the two ends.
// Assumes a pull-up: the line is high unless an end pulls low.
`timescale 1ns/1ps
`default_nettype none
interface swire_if;
  logic lineIn; // Resolved line level
  logic masterOe_b; // Master pulls low when low
  logic devOe_b; // Device pulls low when low
  logic masterOut; // Master drive value, always 0
  logic devOut; // Device drive value, always 0
  // Wired AND of both pull-downs
  assign lineIn = (masterOe_b | masterOut) & (devOe_b | devOut);
  modport master (input lineIn, output masterOe_b, output masterOut);
  modport device (input lineIn, output devOe_b, output devOut);
endinterface
`default_nettype wire

// ==== hw/sync_fifo.sv ====
// Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem [DEPTH]; // Entries
  logic [AW:0] wrPtr_r; // Extra bit tells full from empty
  logic [AW:0] rdPtr_r;
  logic full, empty, doWr, doRd;
  assign full = (wrPtr_r[AW] != rdPtr_r[AW]) &&
                (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
  assign empty = (wrPtr_r == rdPtr_r);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_r[AW-1:0]];
  assign doWr = inValid && !full;
  assign doRd = outReady && !empty;
  // Pointers advance on accepted handshakes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (doWr) wrPtr_r <= wrPtr_r + 1'b1;
      if (doRd) rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
  // Data array, no reset needed
  always_ff @(posedge sys_clk) begin
    if (doWr) mem[wrPtr_r[AW-1:0]] <= inData;
  end
endmodule // sync_fifo
`default_nettype wire

// ==== hw/swire_master.sv ====
// Master end: issues reset, write and read slots from a command port.
// Assumes the interface resolves the wire.
`timescale 1ns/1ps
`default_nettype none
module swire_master (
  input wire logic sys_clk,
  input wire logic rst_b,
  swire_if.master bus,
  input wire logic cmdValid,
  input wire logic [1:0] cmdOp, // swire_pkg::op_t
  input wire logic cmdBit, // Bit to write
  input wire logic cmdFast, // Use fast timing
  output logic cmdReady,
  output logic doneValid, // One-cycle pulse at end
  output logic doneBit // 1 for a read bit of 0 or presence seen
);
  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_LOW = 2'h1, // Driving low
    M_REST = 2'h2 // Released, slot/high time
  } mstate_t;
  typedef struct packed {
    mstate_t st;
    logic [swire_pkg::CNT_W-1:0] cnt, lowLen, endLen, sampAt;
    logic drive, got, done, busy;
    logic sync1, sync2;
  } mst_t;
  mst_t s_r, s_nxt;

  // Sequencer
  always_comb begin
    logic line;
    s_nxt = s_r;
    s_nxt.sync1 = bus.lineIn;
    s_nxt.sync2 = s_r.sync1;
    line = s_r.sync2;
    s_nxt.done = 1'b0;
    s_nxt.cnt = s_r.cnt + 1'b1;
    unique case (s_r.st)
      M_IDLE: begin
        s_nxt.busy = 1'b0;
        if (cmdValid) begin
          s_nxt.busy = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.drive = 1'b1;
          s_nxt.got = 1'b0;
          s_nxt.st = M_LOW;
          if (swire_pkg::op_t'(cmdOp) == swire_pkg::OP_RESET) begin
            s_nxt.lowLen = swire_pkg::CNT_W'(cmdFast ?
              swire_pkg::FAST_RSTL_CYC : swire_pkg::REG_RSTL_CYC);
            // Whole low plus high; M_LOW takes the low part off again
            s_nxt.endLen = swire_pkg::CNT_W'(cmdFast ?
              swire_pkg::FAST_RSTL_CYC + swire_pkg::FAST_RSTH_CYC :
              swire_pkg::REG_RSTL_CYC + swire_pkg::REG_RSTH_CYC);
            s_nxt.sampAt = swire_pkg::CNT_W'(cmdFast ?
              swire_pkg::FAST_PWAIT_CYC + swire_pkg::FAST_PLOW_CYC / 2 :
              swire_pkg::REG_PWAIT_CYC + swire_pkg::REG_PLOW_CYC / 2);
          end else begin
            // low length picks the bit; reads use a one-low
            s_nxt.lowLen = (cmdOp == swire_pkg::OP_WRITE && !cmdBit) ?
              swire_pkg::CNT_W'(cmdFast ? swire_pkg::FAST_ZERO_CYC :
                                swire_pkg::REG_ZERO_CYC) :
              swire_pkg::CNT_W'(cmdFast ? swire_pkg::FAST_ONE_CYC :
                                swire_pkg::REG_ONE_CYC);
            s_nxt.endLen = swire_pkg::CNT_W'(cmdFast ?
              swire_pkg::FAST_SLOT_CYC : swire_pkg::REG_SLOT_CYC) +
              swire_pkg::CNT_W'(swire_pkg::REC_CYC);
            s_nxt.sampAt = swire_pkg::CNT_W'(cmdFast ?
              swire_pkg::FAST_MSAMPLE_CYC : swire_pkg::REG_MSAMPLE_CYC);
          end
        end
      end
      M_LOW: begin
        if (s_r.cnt == s_r.lowLen) begin
          s_nxt.drive = 1'b0;
          s_nxt.st = M_REST;
          s_nxt.cnt = '0;
          s_nxt.endLen = s_r.endLen - s_r.lowLen;
          s_nxt.sampAt = (s_r.sampAt > s_r.lowLen) ?
            s_r.sampAt - s_r.lowLen : s_r.sampAt;
        end
      end
      M_REST: begin
        if (s_r.cnt == s_r.sampAt) s_nxt.got = !line;
        if (s_r.cnt == s_r.endLen) begin
          s_nxt.st = M_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: s_nxt.st = M_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.sync1 <= 1'b1;
      s_r.sync2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.masterOe_b = !s_r.drive;
  assign bus.masterOut = 1'b0;
  assign cmdReady = !s_r.busy;
  assign doneValid = s_r.done;
  assign doneBit = s_r.got; // Reads: 1 if low seen, i.e. bit 0
endmodule // swire_master
`default_nettype wire

// ==== test/swire_assertions.sv ====
// Checker for the single wire link, watching the interface signals.
// Assumes one 40 MHz clock, so 40 cycles make one microsecond.
`timescale 1ns/1ps
`default_nettype none
module swire_assertions (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic lineIn,
  input wire logic masterOe_b,
  input wire logic devOe_b
);
  // ----------------------------------------------------------------
  // Interval counters
  // ----------------------------------------------------------------
  logic [15:0] lowCnt_r; // Cycles the line has been low
  logic [15:0] highCnt_r; // Cycles the line has been high
  logic [15:0] mLowCnt_r; // Cycles the master has pulled
  logic readPull_r; // Device pull belongs to a read slot
  logic presPend_r; // Reset has ended, presence still owed
  // lowCnt_r and highCnt_r saturate so a long idle line never wraps round; mLowCnt_r does not
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_r <= 16'h0000;
      highCnt_r <= 16'hffff;
      mLowCnt_r <= 16'h0000;
      readPull_r <= 1'b0;
      presPend_r <= 1'b0;
    end else begin
      // Set on the rise after a reset-length low, cleared by the pull
      presPend_r <= devOe_b &&
        (presPend_r || (lineIn && lowCnt_r >= 16'h4b00));
      lowCnt_r <= lineIn ? 16'h0000 : lowCnt_r + {15'h0000, ~&lowCnt_r};
      highCnt_r <= lineIn ? highCnt_r + {15'h0000, ~&highCnt_r} : 16'h0000;
      mLowCnt_r <= masterOe_b ? 16'h0000 : mLowCnt_r + 16'h0001;
      readPull_r <= !devOe_b && (readPull_r || !masterOe_b);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Device starts a pull while the line is otherwise idle
  sequence s_pres_start;
    $fell(devOe_b) && masterOe_b;
  endsequence

  // Counted rather than a long delay range, which the tools would unroll
  a_pres_follows: assert property (presPend_r |-> highCnt_r <= 16'h0960)
    else $error("no presence pulse after reset");
  a_pres_wait: assert property (s_pres_start |->
    highCnt_r inside {[16'h0258:16'h0960]})
    else $error("presence wait out of range");
  a_pres_len: assert property ($rose(devOe_b) && !readPull_r |->
    lowCnt_r inside {[16'h0960:16'h2580]})
    else $error("presence length out of range");
  a_read_setup: assert property ($fell(devOe_b) && !masterOe_b |->
    lowCnt_r <= 16'h0028)
    else $error("read bit late on the line");
  a_read_hold: assert property ($rose(devOe_b) && readPull_r |->
    lowCnt_r inside {[16'h0254:16'h0264]})
    else $error("read bit not held for its window");
  a_read_release: assert property (readPull_r |-> lowCnt_r <= 16'h0264)
    else $error("read pull held too long");
  a_master_low: assert property ($rose(masterOe_b) |-> mLowCnt_r inside
    {[16'h0028:16'h0280], [16'h0780:16'h12c0], [16'h4b00:16'h9600]})
    else $error("master low time out of range");
  a_slot_recovery: assert property ($fell(masterOe_b) |->
    highCnt_r >= 16'h0028)
    else $error("recovery time too short");
endmodule // swire_assertions
`default_nettype wire

// ==== test/single_wire_slot_timing_crc_tb.sv ====
// Testbench joining master and device ends through the link.
// Assumes the design runs full-length timing at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module single_wire_slot_timing_crc_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int LIM = 60000; // Longest wait: a reset plus margin
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmdValid = 1'b0, cmdBit = 1'b0, cmdReady, doneValid, doneBit;
  logic [1:0] cmdOp = 2'h0;
  logic txValid = 1'b0, txReady, crcClear = 1'b0, crcSend = 1'b0;
  logic [7:0] txData = 8'h00, rxData;
  logic rxValid, fastMode, presenceDone;
  logic [15:0] crcValue, crc;
  int failures = 0;
  int samples_checked = 0;
  int presCount = 0; // Presence pulses seen
  logic [31:0] seed = 32'h00004bdf; // Fixed start of the sequence
  logic [1:0] doneQ[$]; // {compare, expected low}
  logic [1:0] note;
  logic [7:0] rxQ[$];

  swire_if link();
  swire_master swire_master_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus(link), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdBit(cmdBit),
    .cmdFast(1'b0), .cmdReady(cmdReady), .doneValid(doneValid),
    .doneBit(doneBit));
  swire_device swire_device_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .bus(link), .txValid(txValid), .txReady(txReady), .txData(txData),
    .crcClear(crcClear), .crcSend(crcSend), .rxValid(rxValid),
    .rxData(rxData), .fastMode(fastMode), .presenceDone(presenceDone),
    .crcValue(crcValue));
  swire_assertions swire_assertions_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .lineIn(link.lineIn), .masterOe_b(link.masterOe_b),
    .devOe_b(link.devOe_b));

  // Clock, 25 ns period
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Reflected CRC step, one byte least significant bit first
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ swire_pkg::CRC_POLY_REFL) : c >> 1;
    end
    return c;
  endfunction
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the master to be free
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmdReady !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      failures++;
      finish_test();
    end
  endtask
  // One master operation; the expectation is noted first
  task automatic doOp(input logic [1:0] op, input logic b,
                      input logic [1:0] exp);
    waitIdle();
    doneQ.push_back(exp);
    @(posedge sys_clk);
    cmdOp <= op;
    cmdBit <= b;
    cmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
  endtask
  task automatic writeByte(input logic [7:0] b);
    rxQ.push_back(b);
    for (int i = 0; i < 8; i++) doOp(swire_pkg::OP_WRITE, b[i], 2'b00);
  endtask
  // A read bit of zero shows as line low at the sample
  task automatic readByte(input logic [7:0] e);
    for (int i = 0; i < 8; i++) doOp(swire_pkg::OP_READ, 1'b0, {1'b1, ~e[i]});
  endtask
  task automatic pushTx(input logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (txReady !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      failures++;
      finish_test();
    end
    @(posedge sys_clk);
    txValid <= 1'b1;
    txData <= d;
    @(posedge sys_clk);
    txValid <= 1'b0;
  endtask
  task automatic pulseCrc(input logic send);
    @(posedge sys_clk);
    crcSend <= send;
    crcClear <= !send;
    @(posedge sys_clk);
    crcSend <= 1'b0;
    crcClear <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Output monitor: takes the oldest note as each result appears
  // ----------------------------------------------------------------
  // Sampled on the falling edge, away from the edge that launches them
  always @(negedge sys_clk) begin
    if (doneValid === 1'b1) begin
      note = (doneQ.size() > 0) ? doneQ.pop_front() : 2'b11;
      if (note[1]) check("doneBit", {15'h0000, doneBit}, {15'h0000, note[0]});
    end
    // A byte with no note behind it is a mismatch as well
    if (rxValid === 1'b1) begin
      check("rxData", {8'h00, rxData}, (rxQ.size() > 0) ? {8'h00, rxQ.pop_front()} : 16'hffff);
    end
    if (presenceDone === 1'b1) presCount++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] d;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    // Bus reset with presence answer
    doOp(swire_pkg::OP_RESET, 1'b0, 2'b11);
    waitIdle();
    check("presence", presCount[15:0], 16'h0001);
    check("fastMode", {15'h0000, fastMode}, 16'h0000);
    $display("test reset done");
    // Hash compute frame: command, address low, high, control
    pulseCrc(1'b0);
    crc = 16'h0000;
    d = swire_pkg::CMD_HASH;
    for (int k = 0; k < 4; k++) begin
      writeByte(d);
      crc = crcByte(crc, d);
      seed = xorshift(seed);
      d = seed[7:0];
    end
    waitIdle();
    check("crc hash", crcValue, crc);
    $display("test hash frame done");
    // Device sends a data byte, which the CRC also absorbs
    pushTx(d);
    readByte(d);
    crc = crcByte(crc, d);
    waitIdle();
    check("crc data", crcValue, crc);
    $display("test read done");
    // CRC sent inverted, low byte first
    pulseCrc(1'b1);
    readByte(~crc[7:0]);
    readByte(~crc[15:8]);
    waitIdle();
    $display("test crc send done");
    // Fill the transmit FIFO through the device until it refuses
    n = 0;
    while (n < 40) begin
      @(negedge sys_clk);
      if (txReady !== 1'b1) break;
      @(posedge sys_clk);
      seed = xorshift(seed);
      txValid <= 1'b1;
      txData <= seed[7:0];
      if (n == 0) d = seed[7:0];
      @(posedge sys_clk);
      txValid <= 1'b0;
      n++;
    end
    // Sixteen queued plus the byte already waiting in the shifter
    check("fifo depth", n[15:0], 16'h0011);
    check("fifo full", {15'h0000, txReady}, 16'h0000);
    // Oldest byte leaves first: its low bit on one read slot
    doOp(swire_pkg::OP_READ, 1'b0, {1'b1, ~d[0]});
    waitIdle();
    $display("test fifo done");
    finish_test();
  end
endmodule // single_wire_slot_timing_crc_tb
`default_nettype wire
